/* pkg/led_regs_pkg.sv */
// constants, field layouts and the carrier type for the sink current register bank
// assumes a single 25 MHz clock domain and an I2C slave reached on open-drain pins
//
// What this block does
// - the identification register at address 0 returns the silicon revision in bits 2:0 and ignores writes.
// - bits 7:3 of the identification register return a fixed five-bit pattern that cannot be written.
// - the first sink current register at address 1 is eight read/write bits that reset to 9Ch.
// - in flash mode all eight bits of the current code drive the sink, boost extending the top of the range.
// - in assist mode (10) only bits 6:0 of the current code are used, capping the code at 7Fh.
// - in indicator or low-current pwm mode (01) only bits 5:0 are used, capping the code at 3Fh.
// - the registers answer as serial bus slave 0110000 and the pointer steps after every data byte written.
package led_regs_pkg;

	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam logic [7:0] addr_chip_ident          = 8'h00;
	localparam logic [7:0] addr_sink1_current_level = 8'h01;
	localparam logic [7:0] sink1_current_reset      = 8'h9C;
	localparam logic [6:0] slave_address            = 7'h30;   // 0110000

	// --------------------------------------------------------------
	// field layout of chip_ident
	// --------------------------------------------------------------
	localparam int revision_lsb    = 0;
	localparam int revision_width  = 3;
	localparam int ident_lsb       = 3;
	localparam int ident_width     = 5;

	// --------------------------------------------------------------
	// light modes and code caps
	// --------------------------------------------------------------
	localparam logic [1:0] mode_flash_or_off = 2'h0;
	localparam logic [1:0] mode_indicator    = 2'h1;
	localparam logic [1:0] mode_assist       = 2'h2;
	localparam logic [7:0] mask_assist       = 8'h7F;
	localparam logic [7:0] mask_indicator    = 8'h3F;
	localparam logic [7:0] mask_full         = 8'hFF;

	// --------------------------------------------------------------
	// carrier for the current handed to the analog sink
	// --------------------------------------------------------------
	typedef struct packed {
		logic [7:0] code;
		logic       boost;
	} sink_drive_s;

endpackage

/* logic/led_sink_current_regs.sv */
// i2c slave register bank: chip identification and first sink current code
// assumes scl/sda arrive from the bus asynchronously and are resolved by the bench
`timescale 1ns/100ps
`default_nettype none

module led_sink_current_regs #(
	parameter logic [2:0] revision      = 3'h1,   // arbitrary value
	parameter logic [4:0] ident_pattern = 5'h0A   // arbitrary value
) (
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire logic                      scl_in,
	input  wire logic                      sda_in,
	output logic                           sda_oe_n,
	input  wire logic [1:0]                light_mode,
	input  wire logic                      current_boost,
	output led_regs_pkg::sink_drive_s      first_sink_pin
);

	// --------------------------------------------------------------
	// input synchronisers
	// --------------------------------------------------------------
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_prev;
	logic       sda_prev;

	// first stage feeds only the second
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
		end
	end

	// edges come from the second stage and its delayed copy, never from the first
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	assign scl_rise   = scl_sync[1] & ~scl_prev;
	assign scl_fall   = ~scl_sync[1] & scl_prev;
	assign start_seen = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
	assign stop_seen  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

	// --------------------------------------------------------------
	// register storage and read mux
	// --------------------------------------------------------------
	typedef enum {st_idle, st_addr, st_addr_ack, st_ptr, st_ptr_ack,
	              st_wdata, st_wdata_ack, st_rdata, st_rdata_ack} state_e;
	state_e     state;
	logic [7:0] shift;
	logic [3:0] bit_count;
	logic [7:0] pointer;
	logic [7:0] sink1_current_code;
	logic       write_strobe;
	logic [7:0] read_value;
	// one byte on the wire before the ninth (acknowledge) clock
	localparam logic [3:0] bits_per_byte = 4'h8;

	// read value of any address; unmapped addresses read zero
	function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] cur);
		logic [7:0] v;
		v = 8'h00;
		if (a == led_regs_pkg::addr_chip_ident)
			v = {ident_pattern, revision};
		else if (a == led_regs_pkg::addr_sink1_current_level)
			v = cur;
		return v;
	endfunction

	// one decoder shared by the first read byte and every byte after it
	assign read_value = read_reg(pointer, sink1_current_code);

	// only the current register is writable; ident writes fall away
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sink1_current_code <= led_regs_pkg::sink1_current_reset;
		end else if (write_strobe && pointer == led_regs_pkg::addr_sink1_current_level) begin
			sink1_current_code <= shift;
		end
	end

	// --------------------------------------------------------------
	// bus protocol engine
	// --------------------------------------------------------------
	// the write lands on the fall that ends the ack clock, at the old pointer, in the same cycle the pointer steps
	logic byte_done;
	assign byte_done    = scl_fall && bit_count == bits_per_byte;
	assign write_strobe = scl_fall && state == st_wdata_ack;

	// bits are sampled on scl rise, state steps on scl fall except a host nack, which returns to idle on the rise
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state     <= st_idle;
			shift     <= 8'h00;
			bit_count <= 4'h0;
			pointer   <= 8'h00;
			sda_oe_n  <= 1'b1;
		end else if (start_seen) begin
			// a start anywhere restarts the frame, so a repeated start needs no state
			state     <= st_addr;
			bit_count <= 4'h0;
			sda_oe_n  <= 1'b1;
		end else if (stop_seen) begin
			// a stop even in mid-byte drops the frame and lets go of sda
			state    <= st_idle;
			sda_oe_n <= 1'b1;
		end else begin
			if (scl_rise && (state == st_addr || state == st_ptr || state == st_wdata)) begin
				shift     <= {shift[6:0], sda_sync[1]};
				bit_count <= bit_count + 4'h1;
			end
			if (scl_rise && state == st_rdata) begin
				bit_count <= bit_count + 4'h1;
			end
			// ninth clock of a read byte: a released line is the host's nack
			if (scl_rise && state == st_rdata_ack && sda_sync[1]) begin
				state <= st_idle;   // master nack ends the read
			end
			if (scl_fall) begin
				case (state)
					st_addr: begin
						if (byte_done) begin
							if (shift[7:1] == led_regs_pkg::slave_address) begin
								state    <= st_addr_ack;
								sda_oe_n <= 1'b0;
							end else begin
								state <= st_idle;
							end
						end
					end
					st_addr_ack: begin
						bit_count <= 4'h0;
						if (shift[0]) begin
							// first read byte comes from the stored pointer; msb goes out now
							state    <= st_rdata;
							shift    <= read_value;
							sda_oe_n <= read_value[7];
						end else begin
							state    <= st_ptr;
							sda_oe_n <= 1'b1;
						end
					end
					st_ptr: begin
						if (byte_done) begin
							state    <= st_ptr_ack;
							sda_oe_n <= 1'b0;
						end
					end
					st_ptr_ack: begin
						pointer   <= shift;
						state     <= st_wdata;
						bit_count <= 4'h0;
						sda_oe_n  <= 1'b1;
					end
					st_wdata: begin
						if (byte_done) begin
							state    <= st_wdata_ack;
							sda_oe_n <= 1'b0;
						end
					end
					st_wdata_ack: begin
						pointer   <= pointer + 8'h01;
						state     <= st_wdata;
						bit_count <= 4'h0;
						sda_oe_n  <= 1'b1;
					end
					st_rdata: begin
						if (bit_count == bits_per_byte) begin
							state    <= st_rdata_ack;
							sda_oe_n <= 1'b1;   // release for master ack
							pointer  <= pointer + 8'h01;
						end else begin
							shift    <= {shift[6:0], 1'b0};
							sda_oe_n <= shift[6];
						end
					end
					st_rdata_ack: begin
						state     <= st_rdata;
						bit_count <= 4'h0;
						// pointer already stepped at the end of the previous byte
						shift     <= read_value;
						sda_oe_n  <= read_value[7];
					end
					default: state <= st_idle;
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// mode dependent current code to the sink
	// --------------------------------------------------------------
	// masking here keeps a stale high code from leaking into low modes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			first_sink_pin <= '0;
		end else begin
			// mode 11 keeps the full code like flash but never boosts
			case (light_mode)
				led_regs_pkg::mode_assist:
					first_sink_pin.code <= sink1_current_code & led_regs_pkg::mask_assist;
				led_regs_pkg::mode_indicator:
					first_sink_pin.code <= sink1_current_code & led_regs_pkg::mask_indicator;
				default:
					first_sink_pin.code <= sink1_current_code & led_regs_pkg::mask_full;
			endcase
			// boost only widens the full flash range; host keeps it off below 900mA
			first_sink_pin.boost <= current_boost && light_mode == led_regs_pkg::mode_flash_or_off;
		end
	end

endmodule
`default_nettype wire

/* bench/led_sink_current_regs_properties.sv */
// port checker for the sink current register bank
// assumes a slow bus: scl stays low for several clocks around sda changes
`timescale 1ns/100ps
`default_nettype none
module led_sink_current_regs_properties (
	input wire logic                      clock,
	input wire logic                      rst,
	input wire logic                      scl_in,
	input wire logic                      sda_in,
	input wire logic                      sda_oe_n,
	input wire logic [1:0]                light_mode,
	input wire logic                      current_boost,
	input wire led_regs_pkg::sink_drive_s first_sink_pin
);
	// short views of the sink code and the light mode
	wire logic [7:0] code = first_sink_pin.code;
	wire logic [1:0] m    = light_mode;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ----
	// sink code and bus timing
	// ----
	property p_rel; disable iff (1'b0) rst |-> sda_oe_n; endproperty
	a_rel: assert property (p_rel) else $error("sda pulled in reset");
	property p_rst; $fell(rst) && m == 2'h0 |=> code == 8'h9C; endproperty
	a_rst: assert property (p_rst) else $error("reset code");
	property p_asst; m == 2'h2 |=> !code[7]; endproperty
	a_asst: assert property (p_asst) else $error("assist cap");
	property p_ind; m == 2'h1 |=> code[7:6] == 2'h0; endproperty
	a_ind: assert property (p_ind) else $error("indicator cap");
	property p_bon; (m == 2'h0 && current_boost) [*2] |=> first_sink_pin.boost; endproperty
	a_bon: assert property (p_bon) else $error("boost lost");
	property p_boff; m != 2'h0 |=> !first_sink_pin.boost; endproperty
	a_boff: assert property (p_boff) else $error("boost outside flash");
	// sda may only move while scl is low
	property p_ack; !$stable(sda_oe_n) |-> !scl_in; endproperty
	a_ack: assert property (p_ack) else $error("sda moved with scl high");
	property p_nar; $past(m) == 2'h2 && m == 2'h1 |=> code == ($past(code) & 8'h3F); endproperty
	a_nar: assert property (p_nar) else $error("narrowing");
endmodule
bind led_sink_current_regs led_sink_current_regs_properties chk (.clock, .rst, .scl_in,
	.sda_in, .sda_oe_n, .light_mode, .current_boost, .first_sink_pin);
`default_nettype wire

/* bench/i2c_host_model.sv */
// bus host model driving scl and its side of an open-drain sda
// assumes the bench resolves sda with a pull-up; scl idles high between frames
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
	input  wire logic clock,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_drv
);
	// quarter bit of five clocks leaves the slave time to sync
	task automatic put2(input logic c, input logic d);
		scl = c;
		sda_drv = d;
		repeat (5) @(negedge clock);
	endtask
	initial put2(1'b1, 1'b1);
	// start (to=0) or stop (to=1): sda moves while scl is high
	task automatic cond(input logic to);
		put2(scl, ~to);
		put2(1'b1, ~to);
		put2(1'b1, to);
		if (!to) put2(1'b0, 1'b0);
	endtask
	// byte msb first plus ninth bit; a one releases sda
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			put2(1'b0, d[i]);
			put2(1'b1, d[i]);
			q[i] = sda;
			put2(1'b1, d[i]);
			put2(1'b0, d[i]);
		end
	endtask
endmodule
`default_nettype wire

/* bench/led_sink_current_regs_tb.sv */
// self-checking bench: reference model of the bank against the design
// assumes the host model drives the bus; sda has a pull-up
`timescale 1ns/100ps
`default_nettype none
module led_sink_current_regs_tb;
	// clock starts high so reset rises on the first falling edge, before any sampling edge
	logic                      clock = 1'b1;
	logic                      rst = 1'b0;
	logic [1:0]                light_mode;
	logic                      current_boost;
	logic                      scl;
	logic                      sda_drv;
	logic                      sda_oe_n;
	led_regs_pkg::sink_drive_s first_sink_pin;
	wire logic                 sda = sda_drv & sda_oe_n;
	int                        num_errors, n_compared, cyc, seed = 35, mdl = 'h9C;
	logic [8:0]                q;
	i2c_host_model host (.clock(clock), .sda(sda), .scl(scl), .sda_drv(sda_drv));
	led_sink_current_regs dut (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda),
		.sda_oe_n(sda_oe_n), .light_mode(light_mode), .current_boost(current_boost),
		.first_sink_pin(first_sink_pin));
	initial forever #20 clock = ~clock;
	// ceiling well above the expected run
	always @(posedge clock) begin
		cyc++;
		num_errors += (cyc == 40000);
		if (cyc == 40000) summarize;
	end
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// expected sink drive: mode mask, boost only in flash
	function automatic logic [8:0] exp_pin(input logic [1:0] m, input logic b);
		return {8'(mdl) & (m == 2'h1 ? 8'h3F : m == 2'h2 ? 8'h7F : 8'hFF), b && m == 2'h0};
	endfunction
	task automatic put(input logic [7:0] b);
		host.xfer({b, 1'b1}, q);
		chk({8'h00, q[0]}, 9'h000);
	endtask
	// pointer then two bytes; pointer steps after each
	task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
		host.cond(1'b0);
		put(8'h60);
		put(p);
		put(d0);
		put(d1);
		host.cond(1'b1);
		mdl = p == 8'h01 ? d0 : p == 8'h00 ? d1 : mdl;
	endtask
	// three bytes from p; identity is the arbitrary {0Ah, 1h}
	task automatic rd(input int p);
		host.cond(1'b0);
		put(8'h60);
		put(8'(p));
		host.cond(1'b0);
		put(8'h61);
		for (int a = p; a < p + 3; a++) begin
			host.xfer({8'hFF, a == p + 2}, q);
			chk({q[8:1], 1'b0}, {a == 0 ? {5'h0A, 3'h1} : a == 1 ? 8'(mdl) : 8'h00, 1'b0});
		end
		host.cond(1'b1);
	endtask
	// reset, readback, code writes under every mode, foreign address
	initial begin
		light_mode = 2'h0;
		current_boost = 1'b0;
		@(negedge clock);
		rst = 1'b1;
		repeat (8) @(negedge clock);
		rst = 1'b0;
		repeat (4) @(negedge clock);
		chk(first_sink_pin, exp_pin(2'h0, 1'b0));
		rd(0);
		for (int i = 0; i < 4; i++) begin
			wr(8'(i % 2), 8'($random(seed)), i == 0 ? 8'hFF : 8'($random(seed)));
			current_boost = mdl == 'hFF;
			// fixed sweep 11, 10, 01, 00 covers the narrowings 11 to 10 and 10 to 01, then one random mode
			for (int m = 0; m < 5; m++) begin
				light_mode = m < 4 ? 2'(3 - m) : 2'($random(seed));
				repeat (3) @(negedge clock);
				chk(first_sink_pin, exp_pin(light_mode, current_boost));
			end
			current_boost = 1'b0;
			rd(0);
		end
		host.cond(1'b0);
		host.xfer({8'h62, 1'b1}, q);
		chk(q & 9'h001, 9'h001);
		host.xfer({8'h55, 1'b1}, q);
		host.cond(1'b1);
		// reset in mid-run with the bus idle: the code must fall back to its reset value
		rst = 1'b1;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		mdl = 'h9C;
		repeat (3) @(negedge clock);
		chk(first_sink_pin, exp_pin(light_mode, current_boost));
		rd(1);
		summarize;
	end
endmodule
`default_nettype wire
